// ### rtl/fsled_top.sv
// Behaviour
// - run lamp dark in Init, steadily lit in OP
// - Pre-OP: run lamp 0.2 s dark then 0.2 s lit, repeating
// - Safe-OP: run lamp 1 s dark then 0.2 s lit, repeating
// - error lamp dark when neither a fault nor a watchdog expiry is present
// - fault in Init or Pre-OP: error lamp blinks 0.2 s dark, 0.2 s lit
// - fault in Safe-OP: error lamp 1 s dark then 0.2 s lit
// - fault in OP: error lamp steadily lit
// - watchdog expiry: error lamp double flash, above all other error patterns
// - link/activity lamp: dark without link, lit idle, flickering with traffic
// - yellow lamp dark without link, lit once link is up
// - green lamp dark without link, lit idle, blinking with traffic
// - two ports of fixed direction, index zero is IN, one is OUT
module fsled_top #(
	parameter int unsigned TICK_CYCLES = fsled_pkg::TICK_CYCLES,
	parameter int unsigned NUM_PORTS   = fsled_pkg::NUM_PORTS
) (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  srst,
	// apb slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// protocol controller status
	input  wire logic [1:0]            slaveState,
	input  wire logic                  fault,
	input  wire logic                  wdExpired,
	input  wire logic [NUM_PORTS-1:0]  linkUp,
	input  wire logic [NUM_PORTS-1:0]  linkAct,
	// lamps
	output logic                       runLed,
	output logic                       errLed,
	output logic      [NUM_PORTS-1:0]  laLed,
	output logic      [NUM_PORTS-1:0]  yellowLed,
	output logic      [NUM_PORTS-1:0]  greenLed,
	// interrupt
	output logic                       irq
);
	localparam int unsigned NI = fsled_pkg::INT_LINK + NUM_PORTS;
	// pattern phase width, wide enough for the 32-tick double flash
	localparam int unsigned PW = fsled_pkg::PHASE_W;

	// the divider is the only part that knows the clock rate
	fsled_tick_if tickIf ();

	fsled_timebase #(
		.TICK_CYCLES (TICK_CYCLES)
	) i_fsled_timebase (
		.clk  (clk),
		.srst (srst),
		.tb   (tickIf.src)
	);

	// time base and registers
	logic                  tick;
	logic [1:0]            ctrl;
	logic [NI-1:0]         intStat;
	logic [NI-1:0]         intMask;

	// pattern phases and the lamp levels chosen from them
	logic [PW-1:0]         blinkCnt;
	logic [PW-1:0]         singleCnt;
	logic [PW-1:0]         doubleCnt;
	logic                  flick;
	logic                  blinkOn;
	logic                  singleOn;
	logic                  doubleOn;
	logic                  next_run;
	logic                  next_err;

	// per port activity memory and lamp levels
	logic [NUM_PORTS-1:0]  actSeen;
	logic [NUM_PORTS-1:0]  busy;
	logic [NUM_PORTS-1:0]  next_la;
	logic [NUM_PORTS-1:0]  next_green;

	// event edges, bus strobes and decoded state
	logic [NUM_PORTS-1:0]  linkPrev;
	logic                  wdPrev;
	logic                  faultPrev;
	logic [NI-1:0]         events;
	logic                  wrStb;
	logic                  setup;
	fsled_pkg::fsled_state_type st;

	// tick from the divider; state code cast to the named encoding
	assign tick = tickIf.tick;
	assign st   = fsled_pkg::fsled_state_type'(slaveState);

	// advance a pattern phase, wrapping at its length
	function automatic logic [PW-1:0] step(input logic [PW-1:0] cnt,
		input logic [PW-1:0] len);
		step = (cnt == len - PW'(1)) ? '0 : cnt + PW'(1);
	endfunction

	// true for a mapped register address
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == fsled_pkg::ADDR_CTRL) || (a == fsled_pkg::ADDR_STATUS)
			|| (a == fsled_pkg::ADDR_INTSTAT) || (a == fsled_pkg::ADDR_INTMASK);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// pattern phases; all lamps share them so patterns stay in step
	always_ff @(posedge clk) begin
		if (srst) begin
			blinkCnt  <= '0;
			singleCnt <= '0;
			doubleCnt <= '0;
			flick     <= 1'b0;
		end else if (tick) begin
			blinkCnt  <= step(blinkCnt, fsled_pkg::BLINK_LEN);
			singleCnt <= step(singleCnt, fsled_pkg::SINGLE_LEN);
			doubleCnt <= step(doubleCnt, fsled_pkg::DOUBLE_LEN);
			flick     <= ~flick;
		end
	end

	assign blinkOn  = (blinkCnt >= fsled_pkg::SHORT_TICKS);
	assign singleOn = (singleCnt >= fsled_pkg::LONG_TICKS);
	// two short flashes then long dark
	assign doubleOn = (doubleCnt < fsled_pkg::SHORT_TICKS)
		|| ((doubleCnt >= PW'(2 * fsled_pkg::SHORT_TICKS))
		&& (doubleCnt < PW'(3 * fsled_pkg::SHORT_TICKS)));

	////////////////////////////////////////////////////////////////////////////
	// run and error lamp selection
	always_comb begin
		case (st)
			fsled_pkg::ST_INIT:   next_run = 1'b0;
			fsled_pkg::ST_PREOP:  next_run = blinkOn;
			fsled_pkg::ST_SAFEOP: next_run = singleOn;
			fsled_pkg::ST_OP:     next_run = 1'b1;
			default:              next_run = 1'b0;
		endcase
	end

	// error lamp: watchdog first, then fault presence, then slave state
	always_comb begin
		if (wdExpired) begin
			next_err = doubleOn;
		end else if (!fault) begin
			next_err = 1'b0;
		end else begin
			case (st)
				fsled_pkg::ST_INIT,
				fsled_pkg::ST_PREOP:  next_err = blinkOn;
				fsled_pkg::ST_SAFEOP: next_err = singleOn;
				fsled_pkg::ST_OP:     next_err = 1'b1;
				default:              next_err = 1'b0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// per port activity window and lamps; index PORT_IN faces upstream
	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p++) begin : g_port
			// traffic seen in the current tick window keeps the port busy a full
			// window, so a single short frame darkens the lamp for that window only when flick is low in it
			always_ff @(posedge clk) begin
				if (srst) begin
					actSeen[p] <= 1'b0;
					busy[p]    <= 1'b0;
				end else if (tick) begin
					busy[p]    <= actSeen[p] | linkAct[p];
					actSeen[p] <= 1'b0;
				end else if (linkAct[p]) begin
					actSeen[p] <= 1'b1;
				end
			end

			assign next_la[p]    = linkUp[p] & (busy[p] ? flick : 1'b1);
			assign next_green[p] = linkUp[p] & (busy[p] ? blinkOn : 1'b1);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// lamp drivers; lamp test forces all on, disable forces all off
	// lamps are registered so input glitches never reach a pin
	always_ff @(posedge clk) begin
		if (srst) begin
			runLed    <= 1'b0;
			errLed    <= 1'b0;
			laLed     <= '0;
			yellowLed <= '0;
			greenLed  <= '0;
		end else if (ctrl[fsled_pkg::CTRL_LAMPTEST]) begin
			runLed    <= 1'b1;
			errLed    <= 1'b1;
			laLed     <= '1;
			yellowLed <= '1;
			greenLed  <= '1;
		end else if (!ctrl[fsled_pkg::CTRL_ENABLE]) begin
			runLed    <= 1'b0;
			errLed    <= 1'b0;
			laLed     <= '0;
			yellowLed <= '0;
			greenLed  <= '0;
		end else begin
			runLed    <= next_run;
			errLed    <= next_err;
			laLed     <= next_la;
			yellowLed <= linkUp;
			greenLed  <= next_green;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// event edges for the interrupt status
	always_ff @(posedge clk) begin
		if (srst) begin
			wdPrev    <= 1'b0;
			faultPrev <= 1'b0;
			linkPrev  <= '0;
		end else begin
			wdPrev    <= wdExpired;
			faultPrev <= fault;
			linkPrev  <= linkUp;
		end
	end

	// edges, not levels, so a held fault raises one event and not a stream
	assign events = {linkUp ^ linkPrev, fault & ~faultPrev, wdExpired & ~wdPrev};

	////////////////////////////////////////////////////////////////////////////
	// apb slave: zero wait, read data captured in the setup cycle
	// no wait states, so every access ends in its first access cycle
	assign setup   = psel & ~penable;
	assign wrStb   = psel & penable & pwrite;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped(paddr);
	assign irq     = |(intStat & intMask);

	// control word; enable leaves reset set so lamps work unconfigured
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl <= fsled_pkg::CTRL_RESET;
		end else if (wrStb && paddr == fsled_pkg::ADDR_CTRL) begin
			ctrl <= pwdata[1:0];
		end
	end

	// interrupt mask, same layout as the status
	always_ff @(posedge clk) begin
		if (srst) begin
			intMask <= '0;
		end else if (wrStb && paddr == fsled_pkg::ADDR_INTMASK) begin
			intMask <= pwdata[NI-1:0];
		end
	end

	// sticky status, write one to clear; a new event beats the clear
	// so an event landing in the clearing cycle is never lost
	always_ff @(posedge clk) begin
		if (srst) begin
			intStat <= '0;
		end else if (wrStb && paddr == fsled_pkg::ADDR_INTSTAT) begin
			intStat <= (intStat & ~pwdata[NI-1:0]) | events;
		end else begin
			intStat <= intStat | events;
		end
	end

	// read data loaded at setup, so it stands for the whole access cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			prdata <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			case (paddr)
				fsled_pkg::ADDR_CTRL:    prdata <= {30'h0, ctrl};
				fsled_pkg::ADDR_STATUS:  prdata <= 32'({errLed, runLed,
					linkUp[1:0], wdExpired, fault, slaveState});
				fsled_pkg::ADDR_INTSTAT: prdata <= 32'(intStat);
				fsled_pkg::ADDR_INTMASK: prdata <= 32'(intMask);
				default:                 prdata <= 32'h0000_0000;
			endcase
		end
	end

endmodule // fsled_top

// ### rtl/fsled_pkg.sv
package fsled_pkg;

	////////////////////////////////////////////////////////////////////////////
	// clock and time base
	localparam int unsigned CLK_HZ        = 10_000_000;
	localparam int unsigned TICK_MS       = 50;
	localparam int unsigned MS_PER_S      = 1000;
	localparam int unsigned TICK_CYCLES   = CLK_HZ / MS_PER_S * TICK_MS;

	// pattern lengths in 50 ms ticks (0.2 s = 4, 1 s = 20); six phase bits,
	// as the double flash runs to 32 ticks and would wrap a five bit counter
	localparam int unsigned PHASE_W       = 6;
	localparam int unsigned SHORT_MS      = 200;
	localparam int unsigned LONG_MS       = 1000;
	localparam logic [5:0]  SHORT_TICKS   = 6'(SHORT_MS / TICK_MS);
	localparam logic [5:0]  LONG_TICKS    = 6'(LONG_MS / TICK_MS);
	localparam logic [5:0]  BLINK_LEN     = 6'(2 * SHORT_TICKS);
	localparam logic [5:0]  SINGLE_LEN    = 6'(LONG_TICKS + SHORT_TICKS);
	localparam logic [5:0]  DOUBLE_LEN    = 6'(3 * SHORT_TICKS + LONG_TICKS);

	////////////////////////////////////////////////////////////////////////////
	// network ports: index of the fixed-direction ports
	localparam int unsigned NUM_PORTS     = 2;
	localparam int unsigned PORT_IN       = 0;
	localparam int unsigned PORT_OUT      = 1;

	// slave state machine of the protocol controller
	typedef enum logic [1:0] {
		ST_INIT    = 2'b00,
		ST_PREOP   = 2'b01,
		ST_SAFEOP  = 2'b10,
		ST_OP      = 2'b11
	} fsled_state_type;

	////////////////////////////////////////////////////////////////////////////
	// register map (byte addresses)
	localparam logic [7:0]  ADDR_CTRL     = 8'h00;
	localparam logic [7:0]  ADDR_STATUS   = 8'h04;
	localparam logic [7:0]  ADDR_INTSTAT  = 8'h08;
	localparam logic [7:0]  ADDR_INTMASK  = 8'h0C;

	// control fields
	localparam int unsigned CTRL_ENABLE   = 0;
	localparam int unsigned CTRL_LAMPTEST = 1;
	localparam logic [1:0]  CTRL_RESET    = 2'h1;

	// status fields
	localparam int unsigned STAT_STATE    = 0;
	localparam int unsigned STAT_FAULT    = 2;
	localparam int unsigned STAT_WDOG     = 3;
	localparam int unsigned STAT_LINK     = 4;
	localparam int unsigned STAT_RUNLED   = 6;
	localparam int unsigned STAT_ERRLED   = 7;

	// interrupt events
	localparam int unsigned INT_WDOG      = 0;
	localparam int unsigned INT_FAULT     = 1;
	localparam int unsigned INT_LINK      = 2;
	localparam int unsigned INT_BITS      = 4;

endpackage : fsled_pkg

// ### rtl/fsled_tick_if.sv
interface fsled_tick_if;
	logic tick;
	modport src (output tick);
	modport snk (input tick);
endinterface : fsled_tick_if

// ### rtl/fsled_timebase.sv
module fsled_timebase #(
	parameter int unsigned TICK_CYCLES = fsled_pkg::TICK_CYCLES
) (
	// clock and reset
	input  wire logic     clk,
	input  wire logic     srst,
	// tick out
	fsled_tick_if.src     tb
);
	localparam int unsigned CW = $clog2(TICK_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

	logic [CW-1:0] count;

	////////////////////////////////////////////////////////////////////////////
	// free running divider, one pulse every tick period
	always_ff @(posedge clk) begin
		if (srst || count == LAST) begin
			count <= '0;
		end else begin
			count <= count + CW'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			tb.tick <= 1'b0;
		end else begin
			tb.tick <= (count == LAST);
		end
	end

endmodule // fsled_timebase

// ### test/fsled_sva.sv
module fsled_sva #(
	parameter int unsigned TICK_CYCLES = 10,
	parameter int unsigned NUM_PORTS   = 2
) (
	// clock and reset
	input wire logic                 clk,
	input wire logic                 srst,
	// apb
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [7:0]           paddr,
	input wire logic [31:0]          pwdata,
	input wire logic [31:0]          prdata,
	input wire logic                 pready,
	input wire logic                 pslverr,
	// controller status
	input wire logic [1:0]           slaveState,
	input wire logic                 fault,
	input wire logic                 wdExpired,
	input wire logic [NUM_PORTS-1:0] linkUp,
	input wire logic [NUM_PORTS-1:0] linkAct,
	// lamps and interrupt
	input wire logic                 runLed,
	input wire logic                 errLed,
	input wire logic [NUM_PORTS-1:0] laLed,
	input wire logic [NUM_PORTS-1:0] yellowLed,
	input wire logic [NUM_PORTS-1:0] greenLed,
	input wire logic                 irq
);
	localparam int unsigned LIT = 4 * TICK_CYCLES;
	logic [1:0]  ctl;
	logic [1:0]  prevSt;
	int unsigned litCnt;
	logic        normal;
	assign normal = (ctl == 2'h1);
	// mirror of the control word: forced lamps hide every pattern
	always_ff @(posedge clk) begin
		if (srst)
			ctl <= 2'h1;
		else if (psel && penable && pwrite && paddr == 8'h00)
			ctl <= pwdata[1:0];
	end
	// lit run length in the two blinking states; a state change restarts it
	always_ff @(posedge clk) begin
		prevSt <= slaveState;
		if (srst || !runLed || !normal || !(^slaveState) || slaveState != prevSt)
			litCnt <= 0;
		else
			litCnt <= litCnt + 1;
	end
	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	property p_run_init; normal && slaveState == 2'h0 |=> !runLed; endproperty
	a_run_init: assert property (p_run_init) else $error("run lamp lit in init");
	property p_run_op; normal && slaveState == 2'h3 |=> runLed; endproperty
	a_run_op: assert property (p_run_op) else $error("run lamp dark in op");
	property p_lit; litCnt <= LIT; endproperty
	a_lit: assert property (p_lit) else $error("run lamp lit too long");
	property p_err_off; normal && !fault && !wdExpired |=> !errLed; endproperty
	a_err_off: assert property (p_err_off) else $error("error lamp lit");
	property p_err_op; normal && fault && !wdExpired && slaveState == 2'h3 |=> errLed; endproperty
	a_err_op: assert property (p_err_op) else $error("error lamp dark");
	property p_port_off; normal |=> ((laLed | greenLed) & ~$past(linkUp)) == '0; endproperty
	a_port_off: assert property (p_port_off) else $error("port lamp lit");
	property p_yellow; normal |=> yellowLed == $past(linkUp); endproperty
	a_yellow: assert property (p_yellow) else $error("yellow lamp wrong");
	property p_test; ctl[1] |=> &{runLed, errLed, laLed, yellowLed, greenLed}; endproperty
	a_test: assert property (p_test) else $error("lamp test not lit");
	property p_ready; psel && penable |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("access not ready");
endmodule // fsled_sva

bind fsled_top fsled_sva #(.TICK_CYCLES(TICK_CYCLES), .NUM_PORTS(NUM_PORTS)) i_fsled_sva (.*);

// ### test/fsled_partner.sv
module fsled_partner (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       srst,
	// wanted status {act, up, wd, fault, state}
	input  wire logic [7:0] want,
	// status to the lamp block
	output logic      [1:0] slaveState,
	output logic            fault,
	output logic            wdExpired,
	output logic      [1:0] linkUp,
	output logic      [1:0] linkAct
);
	logic [1:0] ph;
	// status is registered, as the controller drives it off its own clock
	always_ff @(posedge clk) begin
		if (srst) begin
			{linkUp, wdExpired, fault, slaveState} <= '0;
			ph <= 2'h0;
		end else begin
			{linkUp, wdExpired, fault, slaveState} <= want[5:0];
			ph <= ph + 2'h1;
		end
	end
	// traffic comes in single-cycle pulses, and only on a live link
	assign linkAct = (ph == 2'h0) ? (want[7:6] & linkUp) : 2'h0;
endmodule // fsled_partner

// ### test/fsled_top_tb.sv
module fsled_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned TC = 10;
	logic        clk     = 1'b0;
	logic        srst    = 1'b1;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic [7:0]  want    = 8'h00;
	logic [31:0] prdata;
	logic        pready, pslverr, runLed, errLed, irq, fault, wdExpired;
	logic [1:0]  slaveState, linkUp, linkAct, laLed, yellowLed, greenLed;
	logic [7:0]  lamps;
	int          n_errors  = 0;
	int          tests_run = 0;
	assign lamps = {greenLed, yellowLed, laLed, errLed, runLed};
	fsled_top #(.TICK_CYCLES(TC)) i_fsled_top (.*);
	fsled_partner i_fsled_partner (.*);
	// bench clock, 100 ns period
	initial forever #50 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		if (n_errors == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		tests_run++;
		if (s !== x) begin
			n_errors++;
			$display("mismatch %s exp %h seen %h", nm, x, s);
		end
	endtask
	// one apb transfer; an idle edge after it keeps drivers from double assignment
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk("rdata", r, x);
		chk("slverr", 32'(e), 32'(xe));
	endtask
	// settle time covers the two-window activity memory
	task automatic set(input logic [1:0] st, input logic f, input logic wd,
		input logic [1:0] up, input logic [1:0] act);
		want <= {act, up, wd, f, st};
		repeat (30) @(posedge clk);
	endtask
	// lit cycles over whole periods do not depend on the pattern phase
	task automatic cnt(input int b, input int n, input int e);
		int k;
		k = 0;
		repeat (n) begin
			@(posedge clk);
			k += (lamps[b] === 1'b1);
		end
		chk($sformatf("lamp%0d", b), 32'(k), 32'(e));
	endtask
	////////////////////////////////////////////////////////////////////////////
	// watchdog far beyond the few thousand cycles the tests take
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		final_report();
	end
	initial begin
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		repeat (2) @(posedge clk);
		chk("lamps", 32'(lamps), 32'h0);
		rd(fsled_pkg::ADDR_CTRL, 32'h1, 1'b0);
		rd(8'h10, 32'h0, 1'b1);
		set(2'h0, 1'b0, 1'b0, 2'h0, 2'h0);
		cnt(0, 80, 0);
		set(2'h3, 1'b0, 1'b0, 2'h0, 2'h0);
		cnt(0, 80, 80);
		set(2'h1, 1'b0, 1'b0, 2'h0, 2'h0);
		cnt(0, 160, 80);
		set(2'h2, 1'b0, 1'b0, 2'h0, 2'h0);
		cnt(0, 240, 40);
		cnt(1, 80, 0);
		set(2'h0, 1'b1, 1'b0, 2'h0, 2'h0);
		cnt(1, 160, 80);
		set(2'h1, 1'b1, 1'b0, 2'h0, 2'h0);
		cnt(1, 160, 80);
		set(2'h2, 1'b1, 1'b0, 2'h0, 2'h0);
		cnt(1, 240, 40);
		set(2'h3, 1'b1, 1'b0, 2'h0, 2'h0);
		cnt(1, 80, 80);
		rd(fsled_pkg::ADDR_STATUS, 32'hC7, 1'b0);
		wr(fsled_pkg::ADDR_INTSTAT, 32'hF);
		wr(fsled_pkg::ADDR_INTMASK, 32'h1);
		chk("irq", 32'(irq), 32'h0);
		set(2'h3, 1'b1, 1'b1, 2'h0, 2'h0);
		cnt(1, 320, 80);
		rd(fsled_pkg::ADDR_INTSTAT, 32'h1, 1'b0);
		chk("irq", 32'(irq), 32'h1);
		wr(fsled_pkg::ADDR_INTMASK, 32'h0);
		chk("irq", 32'(irq), 32'h0);
		wr(fsled_pkg::ADDR_INTSTAT, 32'h1);
		rd(fsled_pkg::ADDR_INTSTAT, 32'h0, 1'b0);
		set(2'h3, 1'b0, 1'b0, 2'h0, 2'h3);
		cnt(2, 80, 0);
		cnt(4, 80, 0);
		cnt(7, 80, 0);
		set(2'h3, 1'b0, 1'b0, 2'h3, 2'h2);
		cnt(2, 80, 80);
		cnt(3, 200, 100);
		cnt(5, 80, 80);
		cnt(7, 160, 80);
		cnt(6, 80, 80);
		rd(fsled_pkg::ADDR_INTSTAT, 32'hC, 1'b0);
		wr(fsled_pkg::ADDR_CTRL, 32'h3);
		@(posedge clk);
		chk("lamps", 32'(lamps), 32'hFF);
		wr(fsled_pkg::ADDR_CTRL, 32'h0);
		@(posedge clk);
		chk("lamps", 32'(lamps), 32'h0);
		rd(fsled_pkg::ADDR_CTRL, 32'h0, 1'b0);
		final_report();
	end
endmodule // fsled_top_tb
